/* common/rfim_pkg.sv */
/*
 * Constants for the interrupt mask bank: register addresses, field positions,
 * reset values and FIFO level thresholds.
 * Assumes an 8-bit register port with a 6-bit address, as seen by the host
 * port decoder in front of it.
 */
package rfim_pkg;

   localparam int NUM_GROUPS = 4;
   localparam int REG_W = 8;
   localparam int ADDR_W = 6;

   // Mask registers, one per interrupt group, read and write.
   localparam logic [5:0] ADDR_MAIN_MASK = 6'h16;
   localparam logic [5:0] ADDR_TIMER_FIELD_MASK = 6'h17;
   localparam logic [5:0] ADDR_ERROR_WAKEUP_MASK = 6'h18;
   localparam logic [5:0] ADDR_PASSIVE_TARGET_MASK = 6'h19;

   // Status registers, read only, cleared by the read.
   localparam logic [5:0] ADDR_MAIN_STAT = 6'h1a;
   localparam logic [5:0] ADDR_PASSIVE_TARGET_STAT = 6'h1d;

   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // Bits that carry a source in each group; the others always read zero in status.
   localparam logic [7:0] MAIN_SRC_BITS = 8'hfe;
   localparam logic [7:0] TIMER_FIELD_SRC_BITS = 8'hff;
   localparam logic [7:0] ERROR_WAKEUP_SRC_BITS = 8'hff;
   localparam logic [7:0] PASSIVE_TARGET_SRC_BITS = 8'h7b;

   // Main group field positions.
   localparam int MAIN_OSC_BIT = 7;
   localparam int MAIN_FIFO_LEVEL_BIT = 6;

   // FIFO level thresholds in bytes.
   localparam int FIFO_DEPTH = 512;
   localparam int FIFO_RX_HIGH = 300;
   localparam int FIFO_TX_LOW = 200;

endpackage

/* core/rfim_fifo_level.sv */
/*
 * FIFO level event detector: one-cycle pulse when the fill level enters the
 * region that needs host service.
 * Assumes the FIFO count and the rx/tx activity flags are synchronous to sys_clk.
 */
`timescale 1ns/1ps
module rfim_fifo_level #(
   parameter int CNT_W = 10,
   parameter int RX_HIGH = rfim_pkg::FIFO_RX_HIGH,
   parameter int TX_LOW = rfim_pkg::FIFO_TX_LOW
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [CNT_W-1:0] fifo_count,
   input wire logic rx_active,
   input wire logic tx_active,
   output logic level_evt
);

   typedef struct packed {
      logic cond;
      logic evt;
   } rfim_lvl_state_t;

   rfim_lvl_state_t s_q;
   rfim_lvl_state_t s_d;
   logic cond;

   always_comb
   begin
      cond = 1'b0;
      if (rx_active)
      begin
         cond = fifo_count > CNT_W'(RX_HIGH);
      end
      else if (tx_active)
      begin
         cond = fifo_count < CNT_W'(TX_LOW);
      end
      s_d = s_q;
      s_d.cond = cond;
      // Fires once on entry, so a level sitting above threshold does not retrigger.
      s_d.evt = cond && !s_q.cond;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign level_evt = s_q.evt;

   property p_rx_level;
      @(posedge sys_clk) disable iff (reset)
      (rx_active && fifo_count > CNT_W'(RX_HIGH) && !s_q.cond) |=> level_evt;
   endproperty
   a_rx_level: assert property (p_rx_level) else $error("rx level event missing");

   property p_tx_level;
      @(posedge sys_clk) disable iff (reset)
      (!rx_active && tx_active && fifo_count < CNT_W'(TX_LOW) && !s_q.cond) |=> level_evt;
   endproperty
   a_tx_level: assert property (p_tx_level) else $error("tx level event missing");

endmodule

/* core/rfim_status_bank.sv */
/*
 * One interrupt status register: sticky bits set by source events and cleared
 * by a host read. A set arriving in the clearing cycle is kept.
 * Assumes event inputs are one-cycle pulses synchronous to sys_clk.
 */
`timescale 1ns/1ps
module rfim_status_bank #(
   parameter logic [7:0] SRC_BITS = 8'hff
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [7:0] evt,
   input wire logic rd_clr,
   output logic [7:0] status
);

   typedef struct packed {
      logic [7:0] status;
   } rfim_stat_state_t;

   rfim_stat_state_t s_q;
   rfim_stat_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.status = ((rd_clr ? rfim_pkg::STAT_RESET : s_q.status) | evt) & SRC_BITS;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign status = s_q.status;

   property p_set_wins;
      @(posedge sys_clk) disable iff (reset)
      (rd_clr && ((evt & SRC_BITS) != 8'h00)) |=> ((status & $past(evt) & SRC_BITS) == ($past(evt) & SRC_BITS));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost in clear cycle");

endmodule

/* core/rfim_irq_top.sv */
/*
 * Interrupt mask bank: four mask registers, four read-to-clear status
 * registers and the interrupt request output toward the host.
 * Assumes the host port decoder presents one-cycle read and write strobes
 * with a 6-bit address and byte data, synchronous to sys_clk.
 */
`timescale 1ns/1ps
//
// Overview of operation
// - Mask bit 7 of the main mask stops the oscillator-stable event from raising the interrupt.
// - Mask bit 6 of the main mask stops the FIFO fill-level event from raising the interrupt.
// - Main mask bits 5, 4 and 3 stop receive-start, receive-end and transmit-end interrupts.
// - Main mask bit 2 stops bit collision, bit 1 stops reception restart, and bit 0 does nothing.
// - Timer and field mask bits 7, 6, 5 stop command-done, no-response and general timer interrupts.
// - Timer and field mask bit 4 stops field-rise and bit 3 stops field-drop interrupts.
// - Timer and field mask bits 2, 1, 0 stop collision-avoidance, guard-time and bit-rate interrupts.
// - Error and wake-up mask bits 7 to 4 stop CRC, parity, soft and hard framing error interrupts.
// - Error and wake-up mask bits 3 to 0 stop wake-up timer, amplitude, phase and capacitance interrupts.
// - Passive target mask bit 6 stops slot level, bit 5 stops peer field-on, and bit 7 is reserved.
// - Passive target mask bit 4 stops the end-of-receive interrupt of device-handled responses.
// - Passive target mask bit 3 stops high-rate, bits 1 and 0 stop base-rate target interrupts, bit 2 reserved.
// - The four mask registers sit at 16h to 19h and can be written and read back by the host.
// - A status register reads back its bits and is then cleared, keeping only events that arrive in the read cycle.
// - The FIFO level event fires in receive above 300 bytes and, while receive is inactive, in transmit below 200 bytes.
module rfim_irq_top #(
   parameter int CNT_W = 10
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [5:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [7:0] evt_main,
   input wire logic [7:0] evt_timer_field,
   input wire logic [7:0] evt_error_wakeup,
   input wire logic [7:0] evt_passive_target,
   input wire logic [CNT_W-1:0] fifo_count,
   input wire logic rx_active,
   input wire logic tx_active,
   output logic irq
);

   typedef struct packed {
      logic [3:0][7:0] mask;
      logic [7:0] rdata;
      logic rvalid;
      logic irq;
   } rfim_top_state_t;

   localparam logic [3:0][7:0] SRC_BITS = {rfim_pkg::PASSIVE_TARGET_SRC_BITS,
      rfim_pkg::ERROR_WAKEUP_SRC_BITS, rfim_pkg::TIMER_FIELD_SRC_BITS, rfim_pkg::MAIN_SRC_BITS};

   rfim_top_state_t s_q;
   rfim_top_state_t s_d;
   logic [3:0][7:0] evt;
   logic [3:0][7:0] status;
   logic [3:0] rd_clr;
   logic fifo_level_evt;
   logic [31:0] pend_all;
   logic [31:0] mask_all;
   logic [31:0] unmasked;

   rfim_fifo_level #(
      .CNT_W(CNT_W),
      .RX_HIGH(rfim_pkg::FIFO_RX_HIGH),
      .TX_LOW(rfim_pkg::FIFO_TX_LOW)
   ) u_fifo_level (
      .sys_clk(sys_clk),
      .reset(reset),
      .fifo_count(fifo_count),
      .rx_active(rx_active),
      .tx_active(tx_active),
      .level_evt(fifo_level_evt)
   );

   // The FIFO level source comes from the level detector, not from the event port.
   always_comb
   begin
      evt[0] = evt_main;
      evt[0][rfim_pkg::MAIN_FIFO_LEVEL_BIT] = fifo_level_evt;
      evt[1] = evt_timer_field;
      evt[2] = evt_error_wakeup;
      evt[3] = evt_passive_target;
   end

   genvar g;
   generate
      for (g = 0; g < rfim_pkg::NUM_GROUPS; g = g + 1)
      begin : gen_group
         assign rd_clr[g] = reg_rd && (reg_addr == rfim_pkg::ADDR_MAIN_STAT + 6'(g));
         rfim_status_bank #(
            .SRC_BITS(SRC_BITS[g])
         ) u_status (
            .sys_clk(sys_clk),
            .reset(reset),
            .evt(evt[g]),
            .rd_clr(rd_clr[g]),
            .status(status[g])
         );
      end
   endgenerate

   assign pend_all = status;
   assign mask_all = s_q.mask;
   // A set mask bit hides its source; reserved bits never become pending.
   assign unmasked = pend_all & ~mask_all;

   always_comb
   begin
      s_d = s_q;
      s_d.rvalid = reg_rd;
      s_d.rdata = rfim_pkg::RDATA_UNMAPPED;
      if (reg_wr && reg_addr >= rfim_pkg::ADDR_MAIN_MASK && reg_addr <= rfim_pkg::ADDR_PASSIVE_TARGET_MASK)
      begin
         s_d.mask[2'(reg_addr - rfim_pkg::ADDR_MAIN_MASK)] = reg_wdata;
      end
      if (!reg_rd)
      begin
         s_d.rdata = s_q.rdata;
      end
      else if (reg_addr >= rfim_pkg::ADDR_MAIN_MASK && reg_addr <= rfim_pkg::ADDR_PASSIVE_TARGET_MASK)
      begin
         s_d.rdata = s_q.mask[2'(reg_addr - rfim_pkg::ADDR_MAIN_MASK)];
      end
      else if (reg_addr >= rfim_pkg::ADDR_MAIN_STAT && reg_addr <= rfim_pkg::ADDR_PASSIVE_TARGET_STAT)
      begin
         s_d.rdata = status[2'(reg_addr - rfim_pkg::ADDR_MAIN_STAT)];
      end
      s_d.irq = |unmasked;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign reg_rvalid = s_q.rvalid;
   assign irq = s_q.irq;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   property p_osc_masked;
      (pend_all == 32'h0000_0080 && mask_all[7]) |=> !irq;
   endproperty
   a_osc_masked: assert property (p_osc_masked) else $error("masked oscillator event raised irq");

   property p_fifo_level_masked;
      (pend_all == 32'h0000_0040 && mask_all[6]) |=> !irq;
   endproperty
   a_fifo_level_masked: assert property (p_fifo_level_masked) else $error("masked fifo level raised irq");

   property p_rx_start_masked;
      (pend_all == 32'h0000_0020 && mask_all[5]) |=> !irq;
   endproperty
   a_rx_start_masked: assert property (p_rx_start_masked) else $error("masked rx start raised irq");

   property p_collision_masked;
      (pend_all == 32'h0000_0004 && mask_all[2]) |=> !irq;
   endproperty
   a_collision_masked: assert property (p_collision_masked) else $error("masked collision raised irq");

   property p_cmd_done_masked;
      (pend_all == 32'h0000_8000 && mask_all[15]) |=> !irq;
   endproperty
   a_cmd_done_masked: assert property (p_cmd_done_masked) else $error("masked command done raised irq");

   property p_field_rise_masked;
      (pend_all == 32'h0000_1000 && mask_all[12]) |=> !irq;
   endproperty
   a_field_rise_masked: assert property (p_field_rise_masked) else $error("masked field rise raised irq");

   property p_bit_rate_masked;
      (pend_all == 32'h0000_0100 && mask_all[8]) |=> !irq;
   endproperty
   a_bit_rate_masked: assert property (p_bit_rate_masked) else $error("masked bit rate raised irq");

   property p_crc_masked;
      (pend_all == 32'h0080_0000 && mask_all[23]) |=> !irq;
   endproperty
   a_crc_masked: assert property (p_crc_masked) else $error("masked crc error raised irq");

   property p_cap_wakeup_masked;
      (pend_all == 32'h0001_0000 && mask_all[16]) |=> !irq;
   endproperty
   a_cap_wakeup_masked: assert property (p_cap_wakeup_masked) else $error("masked wake-up raised irq");

   property p_slot_level_masked;
      (pend_all == 32'h4000_0000 && mask_all[30]) |=> !irq;
   endproperty
   a_slot_level_masked: assert property (p_slot_level_masked) else $error("masked slot level raised irq");

   property p_pt_rx_end_masked;
      (pend_all == 32'h1000_0000 && mask_all[28]) |=> !irq;
   endproperty
   a_pt_rx_end_masked: assert property (p_pt_rx_end_masked) else $error("masked target rx end raised irq");

   property p_high_rate_masked;
      (pend_all == 32'h0800_0000 && mask_all[27]) |=> !irq;
   endproperty
   a_high_rate_masked: assert property (p_high_rate_masked) else $error("masked high rate raised irq");

   property p_rx_end_masked;
      (pend_all == 32'h0000_0010 && mask_all[4]) |=> !irq;
   endproperty
   a_rx_end_masked: assert property (p_rx_end_masked) else $error("masked rx end raised irq");

   property p_tx_end_masked;
      (pend_all == 32'h0000_0008 && mask_all[3]) |=> !irq;
   endproperty
   a_tx_end_masked: assert property (p_tx_end_masked) else $error("masked tx end raised irq");

   property p_rx_restart_masked;
      (pend_all == 32'h0000_0002 && mask_all[1]) |=> !irq;
   endproperty
   a_rx_restart_masked: assert property (p_rx_restart_masked) else $error("masked rx restart raised irq");

   property p_no_response_masked;
      (pend_all == 32'h0000_4000 && mask_all[14]) |=> !irq;
   endproperty
   a_no_response_masked: assert property (p_no_response_masked) else $error("masked no response raised irq");

   property p_gp_timer_masked;
      (pend_all == 32'h0000_2000 && mask_all[13]) |=> !irq;
   endproperty
   a_gp_timer_masked: assert property (p_gp_timer_masked) else $error("masked general timer raised irq");

   property p_field_drop_masked;
      (pend_all == 32'h0000_0800 && mask_all[11]) |=> !irq;
   endproperty
   a_field_drop_masked: assert property (p_field_drop_masked) else $error("masked field drop raised irq");

   property p_guard_time_masked;
      (pend_all == 32'h0000_0200 && mask_all[9]) |=> !irq;
   endproperty
   a_guard_time_masked: assert property (p_guard_time_masked) else $error("masked guard time raised irq");

   property p_parity_masked;
      (pend_all == 32'h0040_0000 && mask_all[22]) |=> !irq;
   endproperty
   a_parity_masked: assert property (p_parity_masked) else $error("masked parity error raised irq");

   property p_soft_framing_masked;
      (pend_all == 32'h0020_0000 && mask_all[21]) |=> !irq;
   endproperty
   a_soft_framing_masked: assert property (p_soft_framing_masked) else $error("masked soft framing raised irq");

   property p_wakeup_timer_masked;
      (pend_all == 32'h0008_0000 && mask_all[19]) |=> !irq;
   endproperty
   a_wakeup_timer_masked: assert property (p_wakeup_timer_masked) else $error("masked wake-up timer raised irq");

   property p_peer_field_masked;
      (pend_all == 32'h2000_0000 && mask_all[29]) |=> !irq;
   endproperty
   a_peer_field_masked: assert property (p_peer_field_masked) else $error("masked peer field-on raised irq");

   property p_target_base_masked;
      (pend_all == 32'h0100_0000 && mask_all[24]) |=> !irq;
   endproperty
   a_target_base_masked: assert property (p_target_base_masked) else $error("masked base rate raised irq");

   property p_mask_readback;
      (reg_wr && reg_addr == rfim_pkg::ADDR_TIMER_FIELD_MASK && !reg_rd) ##1 (!reg_wr && !reg_rd) ##1
      (reg_rd && reg_addr == rfim_pkg::ADDR_TIMER_FIELD_MASK && !reg_wr) |=>
      (reg_rvalid && reg_rdata == $past(reg_wdata, 3));
   endproperty
   a_mask_readback: assert property (p_mask_readback) else $error("mask readback mismatch");

   property p_read_clears;
      (reg_rd && reg_addr == rfim_pkg::ADDR_MAIN_STAT && evt[0] == 8'h00) |=>
      (reg_rdata == $past(status[0]) && status[0] == 8'h00);
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("status not cleared by read");

   property p_irq_raise;
      (unmasked != 32'h0000_0000) |=> irq;
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("unmasked pending bit without irq");

   property p_irq_drop;
      (unmasked == 32'h0000_0000) [*2] |-> !irq;
   endproperty
   a_irq_drop: assert property (p_irq_drop) else $error("irq high with nothing pending");

   property p_cov_irq;
      $rose(irq);
   endproperty
   c_irq: cover property (p_cov_irq);

   property p_cov_masked_pending;
      (pend_all != 32'h0000_0000) && (unmasked == 32'h0000_0000);
   endproperty
   c_masked_pending: cover property (p_cov_masked_pending);

   property p_cov_read_clear;
      (rd_clr != 4'h0) && irq ##2 !irq;
   endproperty
   c_read_clear: cover property (p_cov_read_clear);

endmodule

/* verification/rfim_host_model.sv */
/*
 * Host model for the interrupt mask bank: drives the register port one access at a time.
 * Assumes the bench calls access only after reset and reads answers from reg_rdata itself.
 */
`timescale 1ns/1ps
module rfim_host_model (
   input wire logic sys_clk,
   output logic [5:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata
);
   initial
   begin
      reg_addr = 6'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // Idle address and data lines show the inverse of the last value and both strobes go low, so stale data never passes for a request.
   task automatic access(input logic [5:0] addr, input logic wr, input logic [7:0] data);
      @(posedge sys_clk);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_wr <= wr;
      reg_rd <= ~wr;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~addr;
      reg_wdata <= ~data;
   endtask
endmodule

/* verification/rf_irq_mask_bank_bench.sv */
/*
 * Self-checking bench for the interrupt mask bank: register access, masking, read clear and FIFO level.
 * Assumes the host model drives the register port and the design answers reads one cycle after the strobe.
 */
`timescale 1ns/1ps
module rf_irq_mask_bank_bench;
   logic sys_clk;
   logic reset;
   logic [5:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic [7:0] evt [4];
   logic [9:0] fifo_count;
   logic rx_active;
   logic tx_active;
   logic irq;
   logic [7:0] exp_q [$];
   logic [7:0] src [4];
   logic [7:0] val;
   int n_mismatch = 0;
   int num_checks = 0;
   int cycles = 0;
   integer seed;

   rfim_irq_top #(.CNT_W(10)) u_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .evt_main(evt[0]), .evt_timer_field(evt[1]), .evt_error_wakeup(evt[2]),
      .evt_passive_target(evt[3]), .fifo_count(fifo_count), .rx_active(rx_active),
      .tx_active(tx_active), .irq(irq));

   rfim_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata));

   initial
   begin
      sys_clk = 1'b0;
   end
   always #12.5 sys_clk = ~sys_clk;

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      u_host.access(a, 1'b1, d);
   endtask

   // The expected answer is noted before the strobe so the monitor pairs it in order.
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host.access(a, 1'b0, 8'h00);
   endtask

   task automatic pulse(input int g, input logic [7:0] v);
      @(posedge sys_clk);
      evt[g] <= v;
      @(posedge sys_clk);
      evt[g] <= 8'h00;
   endtask

   task automatic set_fifo(input logic rx, input logic tx, input logic [9:0] n);
      @(posedge sys_clk);
      rx_active <= rx;
      tx_active <= tx;
      fifo_count <= n;
      tick(4);
   endtask

   always @(posedge sys_clk)
   begin
      if (reg_rvalid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("unexpected_read", reg_rdata, 8'hxx);
         else
            check("reg_rdata", reg_rdata, exp_q.pop_front());
      end
   end

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   initial
   begin
      reset = 1'b1;
      for (int g = 0; g < 4; g++)
         evt[g] = 8'h00;
      fifo_count = 10'h000;
      rx_active = 1'b0;
      tx_active = 1'b0;
      seed = 99;
      // Main bit 6 is fed by the FIFO level detector, not by the event port.
      src[0] = rfim_pkg::MAIN_SRC_BITS & 8'hbf;
      src[1] = rfim_pkg::TIMER_FIELD_SRC_BITS;
      src[2] = rfim_pkg::ERROR_WAKEUP_SRC_BITS;
      src[3] = rfim_pkg::PASSIVE_TARGET_SRC_BITS;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      tick(1);
      check("irq", {7'h00, irq}, 8'h00);
      for (int g = 0; g < 4; g++)
      begin
         rd(rfim_pkg::ADDR_MAIN_MASK + 6'(g), rfim_pkg::MASK_RESET);
         rd(rfim_pkg::ADDR_MAIN_STAT + 6'(g), rfim_pkg::STAT_RESET);
         val = 8'($random(seed));
         wr(rfim_pkg::ADDR_MAIN_MASK + 6'(g), val);
         rd(rfim_pkg::ADDR_MAIN_MASK + 6'(g), val);
      end
      wr(rfim_pkg::ADDR_MAIN_STAT, 8'hff);
      rd(rfim_pkg::ADDR_MAIN_STAT, rfim_pkg::STAT_RESET);
      rd(6'h3f, rfim_pkg::RDATA_UNMAPPED);
      // Each source with only its own mask bit clear, then with only its own mask bit set.
      for (int g = 0; g < 4; g++)
         for (int b = 0; b < 8; b++)
            for (int m = 0; m < 2; m++)
            begin
               val = 8'h01 << b;
               wr(rfim_pkg::ADDR_MAIN_MASK + 6'(g), (m == 1) ? val : ~val);
               pulse(g, val);
               tick(2);
               check("irq", {7'h00, irq}, {7'h00, src[g][b] & (m == 0)});
               rd(rfim_pkg::ADDR_MAIN_STAT + 6'(g), src[g] & val);
               tick(2);
               check("irq", {7'h00, irq}, 8'h00);
            end
      wr(rfim_pkg::ADDR_MAIN_MASK, 8'h00);
      set_fifo(1'b1, 1'b0, 10'd300);
      rd(rfim_pkg::ADDR_MAIN_STAT, 8'h00);
      set_fifo(1'b1, 1'b0, 10'd301);
      check("irq", {7'h00, irq}, 8'h01);
      rd(rfim_pkg::ADDR_MAIN_STAT, 8'h40);
      set_fifo(1'b0, 1'b1, 10'd200);
      rd(rfim_pkg::ADDR_MAIN_STAT, 8'h00);
      set_fifo(1'b0, 1'b1, 10'd199);
      rd(rfim_pkg::ADDR_MAIN_STAT, 8'h40);
      set_fifo(1'b1, 1'b1, 10'd150);
      rd(rfim_pkg::ADDR_MAIN_STAT, 8'h00);
      wr(rfim_pkg::ADDR_MAIN_MASK, 8'h40);
      set_fifo(1'b0, 1'b1, 10'd199);
      check("irq", {7'h00, irq}, 8'h00);
      rd(rfim_pkg::ADDR_MAIN_STAT, 8'h40);
      tick(3);
      rd(rfim_pkg::ADDR_MAIN_STAT, 8'h00);
      // A timer event arriving in the cycle its register is read is kept for the next read.
      fork
         rd(rfim_pkg::ADDR_MAIN_STAT + 6'h01, 8'h00);
         pulse(1, 8'h80);
      join
      rd(rfim_pkg::ADDR_MAIN_STAT + 6'h01, 8'h80);
      tick(2);
      check("pending_reads", 8'(exp_q.size()), 8'h00);
      give_verdict();
   end
endmodule
